// ---- common/nsm_cfg.svh ----
// Purpose: constants for the inter-switch link neighbor state machine
// Assumes: 100 MHz clk_in, synchronous active-high reset
// Notes: timer figures are plain defaults, shortened via module parameters
`ifndef NSM_CFG_SVH
`define NSM_CFG_SVH
`define NSM_CLK_MHZ 100
`define NSM_HELLO_S 20
`define NSM_DEAD_S 80
`define NSM_HELLO_CYC (`NSM_HELLO_S * `NSM_CLK_MHZ * 40'hf4240)
`define NSM_DEAD_CYC (`NSM_DEAD_S * `NSM_CLK_MHZ * 40'hf4240)
`define NSM_TMR_W 40
`endif

// ---- common/nsm_pkg.sv ----
// Purpose: types for the neighbor state machine
// Assumes: nothing
// Notes: gray codes along down-init-exch-ackwait-full path
package nsm_pkg;
  typedef enum logic [2:0] {
    NSM_DOWN = 3'h0,
    NSM_INIT = 3'h1,
    NSM_EXCH = 3'h3,
    NSM_ACKW = 3'h2,
    NSM_FULL = 3'h6,
    NSM_DBW = 3'h7
  } nsm_state_t;
endpackage : nsm_pkg

// ---- logic/nsm_timer.sv ----
// Purpose: restartable interval timer with one-cycle expiry pulse
// Assumes: start and stop never in same cycle from caller (start wins)
// Notes: periodic mode reloads itself on expiry
`timescale 1ns/1ps
`default_nettype none
module nsm_timer #(
  parameter int W = 40,
  parameter logic [W-1:0] PERIOD = 40'h3e8,
  parameter bit PERIODIC = 1'b0
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic start_in,
  input wire logic stop_in,
  output logic expire_out
);
  logic run;
  logic [W-1:0] cnt;
  logic next_run;
  logic [W-1:0] next_cnt;
  logic next_expire;
  always_comb begin
    next_run = run;
    next_cnt = cnt;
    next_expire = 1'b0;
    if (start_in) begin
      next_run = 1'b1;
      next_cnt = PERIOD;
    end else if (stop_in) begin
      next_run = 1'b0;
    end else if (run) begin
      if (cnt <= W'(1)) begin
        next_expire = 1'b1;
        next_run = PERIODIC;
        next_cnt = PERIOD;
      end else begin
        next_cnt = cnt - W'(1);
      end
    end
  end
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      run <= 1'b0;
      cnt <= '0;
      expire_out <= 1'b0;
    end else begin
      run <= next_run;
      cnt <= next_cnt;
      expire_out <= next_expire;
    end
  end
endmodule : nsm_timer
`default_nettype wire

// ---- logic/nsm_neighbor_fsm.sv ----
// Purpose: per-port neighbor state machine for an inter-switch link
// Assumes: message strobes are one-cycle pulses from the frame logic on clk_in
// Notes: one instance per inter-switch port; action outputs are one-cycle pulses
`include "nsm_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module nsm_neighbor_fsm #(
  parameter logic [`NSM_TMR_W-1:0] HELLO_CYC = `NSM_TMR_W'(`NSM_HELLO_CYC),
  parameter logic [`NSM_TMR_W-1:0] DEAD_CYC = `NSM_TMR_W'(`NSM_DEAD_CYC)
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic port_up_in,
  input wire logic port_offline_in,
  input wire logic two_way_in,
  input wire logic one_way_in,
  input wire logic lsu_in,
  input wire logic lsu_db_done_in,
  input wire logic lsu_init_db_in,
  input wire logic lsa_in,
  input wire logic lsa_db_done_in,
  input wire logic db_sent_in,
  output logic [2:0] state_out,
  output logic adjacent_out,
  output logic send_hello_out,
  output logic hello_one_way_out,
  output logic send_db_out,
  output logic send_done_lsu_out,
  output logic issue_lsr_out,
  output logic recompute_out,
  output logic clear_rxmt_out,
  output logic clear_nbr_out
);
  nsm_pkg::nsm_state_t state, next_state;
  logic next_hello, next_one_way, next_db, next_done_lsu, next_lsr, next_route;
  logic next_clr_rxmt, next_clr_nbr, one_way_mode, next_one_way_mode;
  logic hello_start, hello_stop, dead_start, dead_stop;
  logic hello_exp, dead_exp, msg_seen;

  nsm_timer #(.W(`NSM_TMR_W), .PERIOD(HELLO_CYC), .PERIODIC(1'b1)) u_hello (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .start_in(hello_start),
    .stop_in(hello_stop),
    .expire_out(hello_exp)
  );
  nsm_timer #(.W(`NSM_TMR_W), .PERIOD(DEAD_CYC), .PERIODIC(1'b0)) u_dead (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .start_in(dead_start),
    .stop_in(dead_stop),
    .expire_out(dead_exp)
  );

  always_comb begin
    next_state = state;
    next_hello = 1'b0;
    next_db = 1'b0;
    next_done_lsu = 1'b0;
    next_lsr = 1'b0;
    next_route = 1'b0;
    next_clr_rxmt = 1'b0;
    next_clr_nbr = 1'b0;
    next_one_way_mode = one_way_mode;
    hello_start = 1'b0;
    hello_stop = 1'b0;
    dead_start = 1'b0;
    dead_stop = 1'b0;
    msg_seen = 1'b0;
    if (port_offline_in) begin
      next_state = nsm_pkg::NSM_DOWN;
      next_clr_rxmt = 1'b1;
      next_clr_nbr = 1'b1;
      hello_stop = 1'b1;
      dead_stop = 1'b1;
      next_lsr = (state != nsm_pkg::NSM_DOWN);
      next_one_way_mode = 1'b0;
    end else begin
      unique case (state)
        nsm_pkg::NSM_DOWN: begin
          if (port_up_in) begin
            next_state = nsm_pkg::NSM_INIT;
            next_hello = 1'b1;
            hello_start = 1'b1;
            next_one_way_mode = 1'b0;
          end
        end
        nsm_pkg::NSM_INIT: begin
          if (two_way_in) begin
            next_state = nsm_pkg::NSM_EXCH;
            next_db = 1'b1;
            dead_start = 1'b1;
            next_one_way_mode = 1'b0;
            msg_seen = 1'b1;
          end else if (one_way_in) begin
            dead_start = 1'b1;
            msg_seen = 1'b1;
          end
        end
        default: begin
          if (one_way_in) begin
            next_state = nsm_pkg::NSM_INIT;
            next_clr_rxmt = 1'b1;
            msg_seen = 1'b1;
          end else begin
            // a two-way hello must not swallow an update arriving in the same cycle
            if (two_way_in) begin
              dead_start = 1'b1;
              msg_seen = 1'b1;
            end
            unique case (state)
              nsm_pkg::NSM_EXCH: begin
                if (lsu_in && lsu_db_done_in) begin
                  next_state = nsm_pkg::NSM_ACKW;
                  msg_seen = 1'b1;
                end else if (lsa_in && lsa_db_done_in) begin
                  next_state = nsm_pkg::NSM_DBW;
                  msg_seen = 1'b1;
                end
              end
              nsm_pkg::NSM_ACKW: begin
                if (lsa_in && lsa_db_done_in) begin
                  next_state = nsm_pkg::NSM_FULL;
                  next_lsr = 1'b1;
                  next_route = 1'b1;
                  msg_seen = 1'b1;
                end
              end
              nsm_pkg::NSM_DBW: begin
                if (lsu_in && lsu_db_done_in) begin
                  next_state = nsm_pkg::NSM_FULL;
                  next_lsr = 1'b1;
                  next_route = 1'b1;
                  msg_seen = 1'b1;
                end
              end
              nsm_pkg::NSM_FULL: begin
                if (lsu_in && lsu_init_db_in) begin
                  next_state = nsm_pkg::NSM_INIT;
                  next_one_way_mode = 1'b1;
                  msg_seen = 1'b1;
                end else if (lsu_in || lsa_in) begin
                  dead_start = 1'b1;
                  msg_seen = 1'b1;
                end
              end
              default: begin
              end
            endcase
          end
          if (db_sent_in && (state == nsm_pkg::NSM_EXCH || state == nsm_pkg::NSM_ACKW) &&
              next_state == state) begin
            next_done_lsu = 1'b1;
            msg_seen = 1'b1;
          end
        end
      endcase
      // timers after messages; dead expiry ignored if any message was handled this cycle
      if (state != nsm_pkg::NSM_DOWN) begin
        if (hello_exp) begin
          next_hello = 1'b1;
        end
        if (dead_exp && !msg_seen) begin
          next_state = nsm_pkg::NSM_INIT;
          next_clr_nbr = 1'b1;
          next_clr_rxmt = 1'b1;
          dead_stop = 1'b1;
          next_lsr = 1'b1;
          next_route = 1'b0;
          next_db = 1'b0;
          next_done_lsu = 1'b0;
        end
      end
    end
    next_one_way = next_hello && (next_one_way_mode || next_state == nsm_pkg::NSM_INIT);
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      state <= nsm_pkg::NSM_DOWN;
      one_way_mode <= 1'b0;
      state_out <= 3'h0;
      adjacent_out <= 1'b0;
      send_hello_out <= 1'b0;
      hello_one_way_out <= 1'b0;
      send_db_out <= 1'b0;
      send_done_lsu_out <= 1'b0;
      issue_lsr_out <= 1'b0;
      recompute_out <= 1'b0;
      clear_rxmt_out <= 1'b0;
      clear_nbr_out <= 1'b0;
    end else begin
      state <= next_state;
      one_way_mode <= next_one_way_mode;
      state_out <= next_state;
      adjacent_out <= (next_state == nsm_pkg::NSM_FULL);
      send_hello_out <= next_hello;
      hello_one_way_out <= next_one_way;
      send_db_out <= next_db;
      send_done_lsu_out <= next_done_lsu;
      issue_lsr_out <= next_lsr;
      recompute_out <= next_route;
      clear_rxmt_out <= next_clr_rxmt;
      clear_nbr_out <= next_clr_nbr;
    end
  end
endmodule : nsm_neighbor_fsm
`default_nettype wire

// ---- tb/nsm_fsm_props.sv ----
// Purpose: port checker for the neighbor state machine
// Assumes: single clock, synchronous active-high reset
// Notes: bound into every nsm_neighbor_fsm instance
`include "nsm_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module nsm_fsm_props #(
  parameter logic [`NSM_TMR_W-1:0] HELLO_CYC = `NSM_TMR_W'(50),
  parameter logic [`NSM_TMR_W-1:0] DEAD_CYC = `NSM_TMR_W'(200)
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic port_up_in,
  input wire logic port_offline_in,
  input wire logic two_way_in,
  input wire logic one_way_in,
  input wire logic lsu_in,
  input wire logic lsu_db_done_in,
  input wire logic lsu_init_db_in,
  input wire logic lsa_in,
  input wire logic lsa_db_done_in,
  input wire logic db_sent_in,
  input wire logic [2:0] state_out,
  input wire logic adjacent_out,
  input wire logic send_hello_out,
  input wire logic hello_one_way_out,
  input wire logic send_db_out,
  input wire logic send_done_lsu_out,
  input wire logic issue_lsr_out,
  input wire logic recompute_out,
  input wire logic clear_rxmt_out,
  input wire logic clear_nbr_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);
  logic busy;
  assign busy = port_offline_in | one_way_in | lsu_in | lsa_in;
  a_offline_down: assert property (port_offline_in |=> state_out == 3'h0 && !adjacent_out)
    else $error("offline did not force down");
  a_up_init: assert property (state_out == 3'h0 && port_up_in && !port_offline_in |=>
    state_out == 3'h1 && send_hello_out && hello_one_way_out) else $error("port up not handled");
  a_two_way_exch: assert property (state_out == 3'h1 && two_way_in && !busy |=>
    state_out == 3'h3 && send_db_out) else $error("two-way hello in init not handled");
  a_lsu_ackwait: assert property (state_out == 3'h3 && lsu_in && lsu_db_done_in && !port_offline_in
    && !one_way_in |=> state_out == 3'h2) else $error("complete update missed");
  a_full_entry: assert property ($rose(adjacent_out) |-> recompute_out && issue_lsr_out)
    else $error("full entry actions missing");
  a_down_silent: assert property (state_out == 3'h0 |-> !send_hello_out)
    else $error("hello sent in down");
  a_done_lsu: assert property ((state_out == 3'h3 || state_out == 3'h2) && db_sent_in && !busy
    |=> send_done_lsu_out && $stable(state_out)) else $error("empty complete update missing");
  a_one_way_init: assert property (state_out[1] && one_way_in && !port_offline_in |=>
    state_out == 3'h1 && clear_rxmt_out) else $error("one-way hello not handled");
  c_full: cover property (state_out == 3'h6);
  c_dead: cover property ($rose(clear_nbr_out));
  c_offline: cover property (port_offline_in && adjacent_out);
endmodule : nsm_fsm_props
bind nsm_neighbor_fsm nsm_fsm_props #(.HELLO_CYC(HELLO_CYC), .DEAD_CYC(DEAD_CYC)) u_props (
  .clk_in(clk_in),
  .rst_in(rst_in),
  .port_up_in(port_up_in),
  .port_offline_in(port_offline_in),
  .two_way_in(two_way_in),
  .one_way_in(one_way_in),
  .lsu_in(lsu_in),
  .lsu_db_done_in(lsu_db_done_in),
  .lsu_init_db_in(lsu_init_db_in),
  .lsa_in(lsa_in),
  .lsa_db_done_in(lsa_db_done_in),
  .db_sent_in(db_sent_in),
  .state_out(state_out),
  .adjacent_out(adjacent_out),
  .send_hello_out(send_hello_out),
  .hello_one_way_out(hello_one_way_out),
  .send_db_out(send_db_out),
  .send_done_lsu_out(send_done_lsu_out),
  .issue_lsr_out(issue_lsr_out),
  .recompute_out(recompute_out),
  .clear_rxmt_out(clear_rxmt_out),
  .clear_nbr_out(clear_nbr_out)
);
`default_nettype wire

// ---- tb/nsm_peer.sv ----
// Purpose: far-side model reporting that the database has gone out
// Assumes: send_db_in is a one-cycle pulse
// Notes: DLY sets how slowly the transfer completes
`timescale 1ns/1ps
`default_nettype none
module nsm_peer #(parameter int DLY = 3) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic send_db_in,
  output logic db_sent_out
);
  int cnt;
  always_ff @(posedge clk_in) begin
    if (rst_in) cnt <= 0;
    else if (send_db_in) cnt <= DLY;
    else if (cnt > 0) cnt <= cnt - 1;
  end
  assign db_sent_out = (cnt == 1);
endmodule : nsm_peer
`default_nettype wire

// ---- tb/testbench.sv ----
// Purpose: self-checking bench for the neighbor state machine
// Assumes: shortened hello 50 and dead 200 cycles
// Notes: each scenario task drives one scenario and judges it; ev and stop_test are helpers
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin n_errors++; \
  $display("unexpected at %0t: got %h expected %h", $time, a, b); end end
module testbench;
  localparam int DEAD = 200;
  localparam logic [8:0] UP = 9'h100, OFF = 9'h080, TW = 9'h040, OW = 9'h020, LSU = 9'h010;
  localparam logic [8:0] LD = 9'h008, LI = 9'h004, LSA = 9'h002, AD = 9'h001;
  logic clk_in = 1'b0, rst_in = 1'b1, db_sent;
  logic [8:0] ev_v = 9'h000;
  logic [2:0] state;
  logic adj, hello, hello_ow, send_db, done_lsu, lsr, recomp, clr_rxmt, clr_nbr;
  int n_errors = 0, compares = 0, cyc = 0, i, hc;
  always #5 clk_in = ~clk_in;
  nsm_neighbor_fsm #(.HELLO_CYC(40'h32), .DEAD_CYC(40'hc8)) dut (.clk_in(clk_in), .rst_in(rst_in),
    .port_up_in(ev_v[8]), .port_offline_in(ev_v[7]), .two_way_in(ev_v[6]), .one_way_in(ev_v[5]),
    .lsu_in(ev_v[4]), .lsu_db_done_in(ev_v[3]), .lsu_init_db_in(ev_v[2]), .lsa_in(ev_v[1]),
    .lsa_db_done_in(ev_v[0]), .db_sent_in(db_sent), .state_out(state), .adjacent_out(adj),
    .send_hello_out(hello), .hello_one_way_out(hello_ow), .send_db_out(send_db),
    .send_done_lsu_out(done_lsu), .issue_lsr_out(lsr), .recompute_out(recomp),
    .clear_rxmt_out(clr_rxmt), .clear_nbr_out(clr_nbr));
  nsm_peer #(.DLY(3)) peer (.clk_in(clk_in), .rst_in(rst_in), .send_db_in(send_db), .db_sent_out(db_sent));
  task automatic ev(input logic [8:0] v);
    @(posedge clk_in);
    ev_v <= v;
    @(posedge clk_in);
    ev_v <= 9'h000;
    #1;
  endtask : ev
  task automatic walk_full;
    ev(UP);
    `CHK({state, hello, hello_ow}, 5'h07)
    ev(TW);
    `CHK({state, send_db}, 4'h7)
    for (i = 0; i < 20 && done_lsu !== 1'b1; i++) begin @(posedge clk_in); #1; end
    `CHK({state, done_lsu}, 4'h7)
    ev(LSU | LD);
    `CHK(state, 3'h2)
    ev(LSA | AD);
    `CHK({state, adj, lsr, recomp}, 6'h37)
  endtask : walk_full
  task automatic full_lsu;
    ev(LSA);
    `CHK(state, 3'h6)
    ev(LSU | LI);
    `CHK(state, 3'h1)
  endtask : full_lsu
  task automatic dead_expiry;
    ev(TW);
    hc = 0;
    for (i = 0; i < DEAD + 20 && state !== 3'h1; i++) begin @(posedge clk_in); #1; hc += hello; end
    `CHK(i > DEAD - 10 && i < DEAD + 10, 1'b1)
    `CHK({lsr, clr_nbr}, 2'h3)
    `CHK(hc >= 3, 1'b1)
  endtask : dead_expiry
  task automatic one_way_drop;
    ev(TW);
    ev(TW);
    `CHK(state, 3'h3)
    ev(OW);
    `CHK({state, clr_rxmt}, 4'h3)
  endtask : one_way_drop
  task automatic init_one_way;
    // one-way hello late in init must push the dead expiry a full interval out
    repeat (100) @(posedge clk_in);
    ev(OW);
    `CHK(state, 3'h1)
    for (i = 0; i < DEAD + 20 && clr_nbr !== 1'b1; i++) begin @(posedge clk_in); #1; end
    `CHK(i > DEAD - 10 && i < DEAD + 10, 1'b1)
  endtask : init_one_way
  task automatic db_wait_path;
    ev(TW);
    ev(LSA | AD);
    `CHK(state, 3'h7)
    ev(LSU | LD);
    `CHK({state, adj, lsr, recomp}, 6'h37)
  endtask : db_wait_path
  task automatic offline_down;
    ev(OFF | LSU | LD);
    `CHK({state, lsr, clr_nbr}, 5'h03)
    ev(TW | LSU | LD);
    `CHK(state, 3'h0)
    hc = 0;
    repeat (60) begin @(posedge clk_in); #1; hc += hello; end
    `CHK(hc, 0)
  endtask : offline_down
  task automatic stop_test;
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : stop_test
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_errors++;
      stop_test();
    end
  end
  initial begin
    repeat (8) @(posedge clk_in);
    rst_in <= 1'b0;
    walk_full();
    full_lsu();
    dead_expiry();
    one_way_drop();
    init_one_way();
    db_wait_path();
    offline_down();
    stop_test();
  end
endmodule : testbench
`default_nettype wire
